//--- core/rmd_pkg.sv
// Purpose: Shared constants and types for the reset, microcode and diagnostic command block.
// Assumes: Byte-wide task-file registers, each in the low byte of one aligned 32-bit word.
// Notes: Timing counts are cycles of clk_i at 250 MHz.
package rmd_pkg;
  // Command codes and microcode subcommands.
  localparam logic [7:0] CMD_DEV_RESET = 8'h08;
  localparam logic [7:0] CMD_DIAG = 8'h90;
  localparam logic [7:0] CMD_UCODE = 8'h92;
  localparam logic [7:0] SUB_TEMP = 8'h01;
  localparam logic [7:0] SUB_SAVE = 8'h07;
  // Register byte addresses on the bus.
  localparam logic [7:0] ADR_FEAT = 8'h00;
  localparam logic [7:0] ADR_CNT_LO = 8'h04;
  localparam logic [7:0] ADR_CNT_HI = 8'h08;
  localparam logic [7:0] ADR_TRK_LO = 8'h0c;
  localparam logic [7:0] ADR_TRK_HI = 8'h10;
  localparam logic [7:0] ADR_DSEL = 8'h14;
  localparam logic [7:0] ADR_CMD = 8'h18;
  localparam logic [7:0] ADR_ERR = 8'h1c;
  localparam logic [7:0] ADR_STAT = 8'h20;
  localparam logic [7:0] ADR_DATA = 8'h24;
  localparam logic [7:0] ADR_CFG = 8'h28;
  // Status, error and select bit positions.
  localparam int ST_BSY = 7;
  localparam int ST_DRDY = 6;
  localparam int ST_DF = 5;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  localparam int ERR_ABRT = 2;
  localparam int DSEL_DEV = 4;
  // Configuration bits and their reset value.
  localparam int CFG_PACKET = 0;
  localparam int CFG_DEV1 = 1;
  localparam int CFG_SLEEP = 2;
  localparam int CFG_SUP_TEMP = 3;
  localparam int CFG_SUP_SAVE = 4;
  localparam logic [4:0] CFG_RESET = 5'h18;
  // Diagnostic pass codes.
  localparam logic [7:0] DIAG_PASS0 = 8'h01;
  localparam logic [7:0] DIAG_PASS1 = 8'h81;
  // Block geometry and timing counts.
  localparam int BLOCK_BYTES = 512;
  localparam int BLOCK_WORDS = BLOCK_BYTES / 2;
  localparam int RESET_CYCLES_DEF = 16;
  localparam int DIAG_CYCLES_DEF = 32;
  // Command sequencer states.
  typedef enum logic [2:0] {ST_IDLE, ST_RESET, ST_DIAG, ST_XFER, ST_CHECK} rmd_state_type;
endpackage

//--- core/rmd_mem_if.sv
// Purpose: Carries the write and read ports of the microcode block buffer.
// Assumes: One writer (the sequencer) and one reader (firmware side).
// Notes: Read data is registered inside the memory.
`timescale 1ns/1ps
`default_nettype none
interface rmd_mem_if #(parameter int AW = 8, parameter int DW = 16);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface
`default_nettype wire

//--- core/rmd_ucode_mem.sv
// Purpose: Holds the most recent microcode block for firmware to inspect.
// Assumes: Depth is one block of 16-bit words.
// Notes: No reset on the array; read data appears one cycle after the address.
`timescale 1ns/1ps
`default_nettype none
module rmd_ucode_mem #(
  parameter int AW = 8,
  parameter int DW = 16
) (
  // Clock.
  input wire logic clk_i,
  // Buffer ports.
  rmd_mem_if.mem m
);
  logic [DW-1:0] mem_array [0:(1<<AW)-1];

  // Write port.
  always_ff @(posedge clk_i)
  begin
    if (m.wr_en)
    begin
      mem_array[m.wr_addr] <= m.wr_data;
    end
  end

  // Registered read port.
  always_ff @(posedge clk_i)
  begin
    m.rd_data <= mem_array[m.rd_addr];
  end
endmodule
`default_nettype wire

//--- core/rmd_cmd_core.sv
// Purpose: Device-side handling of per-device reset, microcode download and diagnostics.
// Assumes: Classic Wishbone slave; firmware inputs come from logic on clk_i.
// Notes: Task-file registers sit in the low byte of each word; upper bits read zero.
//
// Decided for this implementation: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module rmd_cmd_core #(
  parameter int RESET_CYCLES = rmd_pkg::RESET_CYCLES_DEF,
  parameter int DIAG_CYCLES = rmd_pkg::DIAG_CYCLES_DEF,
  parameter logic [7:0] DIAG_FAIL0 = 8'h02,
  parameter logic [7:0] DIAG_FAIL1 = 8'h82,
  // Signature values are arbitrary.
  parameter logic [7:0] SIG_CNT = 8'h01,
  parameter logic [7:0] SIG_NUM = 8'h01,
  parameter logic [7:0] SIG_TRK_LO = 8'h00,
  parameter logic [7:0] SIG_TRK_HI = 8'h00
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Firmware side.
  input wire logic diag_fail_i,
  input wire logic dev_fault_i,
  input wire logic ucode_accept_i,
  input wire logic ucode_reject_i,
  input wire logic [7:0] ucode_rd_addr_i,
  output logic [15:0] ucode_rd_data_o,
  output logic ucode_check_o,
  output logic ucode_apply_o,
  output logic ucode_keep_o
);
  localparam logic [15:0] RST_LOAD = 16'(RESET_CYCLES - 1);
  localparam logic [15:0] DIAG_LOAD = 16'(DIAG_CYCLES - 1);
  localparam logic [7:0] LAST_WORD = 8'(rmd_pkg::BLOCK_WORDS - 1);
  // Counts must fit the 16-bit counter and be at least one cycle.
  if (RESET_CYCLES < 1 || RESET_CYCLES > 65536 || DIAG_CYCLES < 1 || DIAG_CYCLES > 65536)
  begin : g_bad_count
    $error("cycle counts out of range");
  end
  rmd_pkg::rmd_state_type state;
  logic [7:0] feat, cnt_lo, cnt_hi, trk_lo, trk_hi, dsel, err;
  logic [4:0] cfg;
  logic bsy, drdy, df, drq, errb;
  logic [15:0] cnt, blocks;
  logic [7:0] widx;
  logic [31:0] next_rdata;
  logic wr_req, cmd_wr, selected, idle, rst_go, rst_abort, diag_go, ucode_cmd, sub_ok;
  logic ucode_abort, ucode_go, other_abort, abort, data_wr, sig_load;
  logic [7:0] cmd, diag_code;
  logic [15:0] count_total;
  rmd_mem_if #(.AW(8), .DW(16)) mbus ();
  rmd_ucode_mem #(.AW(8), .DW(16)) u_mem (
    .clk_i(clk_i),
    .m(mbus.mem)
  );
  // A write lands on the edge at which the master sees ack.
  assign wr_req = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign cmd_wr = wr_req && wb_adr_i == rmd_pkg::ADR_CMD && wb_sel_i[0];
  assign cmd = wb_dat_i[7:0];
  assign selected = dsel[rmd_pkg::DSEL_DEV] == cfg[rmd_pkg::CFG_DEV1];
  assign idle = state == rmd_pkg::ST_IDLE;
  assign count_total = {cnt_hi, cnt_lo};
  // Command acceptance; reset bypasses busy, request and sleep checks.
  assign rst_go = cmd_wr && cmd == rmd_pkg::CMD_DEV_RESET && selected && cfg[rmd_pkg::CFG_PACKET];
  assign rst_abort = cmd_wr && cmd == rmd_pkg::CMD_DEV_RESET && selected && !cfg[rmd_pkg::CFG_PACKET] && idle;
  assign diag_go = cmd_wr && cmd == rmd_pkg::CMD_DIAG && idle && !cfg[rmd_pkg::CFG_SLEEP];
  assign ucode_cmd = cmd_wr && cmd == rmd_pkg::CMD_UCODE && selected && idle && !cfg[rmd_pkg::CFG_SLEEP];
  assign sub_ok = (feat == rmd_pkg::SUB_TEMP && cfg[rmd_pkg::CFG_SUP_TEMP])
    || (feat == rmd_pkg::SUB_SAVE && cfg[rmd_pkg::CFG_SUP_SAVE]);
  assign ucode_abort = ucode_cmd && (cfg[rmd_pkg::CFG_PACKET] || !sub_ok);
  assign ucode_go = ucode_cmd && !ucode_abort;
  assign other_abort = cmd_wr && idle && selected && !cfg[rmd_pkg::CFG_SLEEP]
    && cmd != rmd_pkg::CMD_DEV_RESET && cmd != rmd_pkg::CMD_DIAG && cmd != rmd_pkg::CMD_UCODE;
  assign abort = rst_abort || ucode_abort || other_abort;
  assign data_wr = wr_req && wb_adr_i == rmd_pkg::ADR_DATA && wb_sel_i[1:0] == 2'b11
    && state == rmd_pkg::ST_XFER;
  assign sig_load = (state == rmd_pkg::ST_RESET || state == rmd_pkg::ST_DIAG) && cnt == 16'h0000;
  assign diag_code = cfg[rmd_pkg::CFG_DEV1] ? (diag_fail_i ? DIAG_FAIL1 : rmd_pkg::DIAG_PASS1)
    : (diag_fail_i ? DIAG_FAIL0 : rmd_pkg::DIAG_PASS0);
  // Microcode words go straight into the buffer; no format check is made.
  assign mbus.wr_en = data_wr;
  assign mbus.wr_addr = widx;
  assign mbus.wr_data = wb_dat_i[15:0];
  assign mbus.rd_addr = ucode_rd_addr_i;
  assign ucode_rd_data_o = mbus.rd_data;
  assign ucode_check_o = state == rmd_pkg::ST_CHECK;
  // Bus acknowledge: one wait cycle, dropped the cycle after it is given.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end
  // Read data selection; unmapped and write-only addresses read zero.
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    unique case (wb_adr_i)
      rmd_pkg::ADR_CNT_LO: next_rdata[7:0] = cnt_lo;
      rmd_pkg::ADR_CNT_HI: next_rdata[7:0] = cnt_hi;
      rmd_pkg::ADR_TRK_LO: next_rdata[7:0] = trk_lo;
      rmd_pkg::ADR_TRK_HI: next_rdata[7:0] = trk_hi;
      rmd_pkg::ADR_DSEL: next_rdata[7:0] = dsel;
      rmd_pkg::ADR_ERR: next_rdata[7:0] = err;
      rmd_pkg::ADR_STAT: next_rdata[7:0] = {bsy, drdy, df, 1'b0, drq, 2'b00, errb};
      rmd_pkg::ADR_CFG: next_rdata[4:0] = cfg;
      default: next_rdata = 32'h0000_0000;
    endcase
  end
  // Read data is captured on the edge that raises ack.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_dat_o <= 32'h0000_0000;
    end
    else if (wb_cyc_i && wb_stb_i && !wb_ack_o)
    begin
      wb_dat_o <= next_rdata;
    end
  end

  // Task-file and configuration registers; signature load wins over a host write.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      feat <= 8'h00;
      cnt_lo <= 8'h00;
      cnt_hi <= 8'h00;
      trk_lo <= 8'h00;
      trk_hi <= 8'h00;
      dsel <= 8'h00;
      cfg <= rmd_pkg::CFG_RESET;
    end
    else
    begin
      if (wr_req && wb_sel_i[0])
      begin
        unique case (wb_adr_i)
          rmd_pkg::ADR_FEAT: feat <= wb_dat_i[7:0];
          rmd_pkg::ADR_CNT_LO: cnt_lo <= wb_dat_i[7:0];
          rmd_pkg::ADR_CNT_HI: cnt_hi <= wb_dat_i[7:0];
          rmd_pkg::ADR_TRK_LO: trk_lo <= wb_dat_i[7:0];
          rmd_pkg::ADR_TRK_HI: trk_hi <= wb_dat_i[7:0];
          rmd_pkg::ADR_DSEL: dsel <= wb_dat_i[7:0];
          rmd_pkg::ADR_CFG: cfg <= wb_dat_i[4:0];
          default: ;
        endcase
      end
      if (sig_load)
      begin
        cnt_lo <= SIG_CNT;
        cnt_hi <= SIG_NUM;
        trk_lo <= SIG_TRK_LO;
        trk_hi <= SIG_TRK_HI;
        dsel <= 8'(cfg[rmd_pkg::CFG_DEV1]) << rmd_pkg::DSEL_DEV;
      end
      // Reset wakes the device out of sleep by itself.
      if (rst_go)
      begin
        cfg[rmd_pkg::CFG_SLEEP] <= 1'b0;
      end
    end
  end

  // Command sequencer with status and error results.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= rmd_pkg::ST_IDLE;
      cnt <= 16'h0000;
      blocks <= 16'h0000;
      widx <= 8'h00;
      bsy <= 1'b0;
      drdy <= 1'b1;
      df <= 1'b0;
      drq <= 1'b0;
      errb <= 1'b0;
      err <= 8'h00;
    end
    else if (rst_go)
    begin
      // Reset preempts any command in progress, including a data phase.
      state <= rmd_pkg::ST_RESET;
      cnt <= RST_LOAD;
      bsy <= 1'b1;
      drq <= 1'b0;
    end
    else
    begin
      unique case (state)
        rmd_pkg::ST_IDLE:
        begin
          if (diag_go)
          begin
            state <= rmd_pkg::ST_DIAG;
            cnt <= DIAG_LOAD;
            bsy <= 1'b1;
          end
          else if (ucode_go)
          begin
            widx <= 8'h00;
            blocks <= count_total;
            bsy <= 1'b1;
            state <= rmd_pkg::ST_CHECK;
            if (count_total != 16'h0000)
            begin
              state <= rmd_pkg::ST_XFER;
              bsy <= 1'b0;
              drq <= 1'b1;
            end
          end
          else if (abort)
          begin
            err <= 8'h01 << rmd_pkg::ERR_ABRT;
            errb <= 1'b1;
            df <= dev_fault_i;
            drdy <= 1'b1;
          end
        end
        rmd_pkg::ST_XFER:
        begin
          if (data_wr)
          begin
            widx <= 8'(widx + 8'h01);
            if (widx == LAST_WORD)
            begin
              blocks <= 16'(blocks - 16'h0001);
              if (blocks == 16'h0001)
              begin
                state <= rmd_pkg::ST_CHECK;
                drq <= 1'b0;
                bsy <= 1'b1;
              end
            end
          end
        end
        rmd_pkg::ST_CHECK:
        begin
          // A reject arriving with an accept wins: keeping bad code is the worse hazard.
          if (ucode_reject_i)
          begin
            state <= rmd_pkg::ST_IDLE;
            err <= 8'h01 << rmd_pkg::ERR_ABRT;
            errb <= 1'b1;
            df <= dev_fault_i;
            bsy <= 1'b0;
            drq <= 1'b0;
            drdy <= 1'b1;
          end
          else if (ucode_accept_i)
          begin
            state <= rmd_pkg::ST_IDLE;
            err <= 8'h00;
            errb <= 1'b0;
            df <= 1'b0;
            bsy <= 1'b0;
            drq <= 1'b0;
            drdy <= 1'b1;
          end
        end
        rmd_pkg::ST_RESET, rmd_pkg::ST_DIAG:
        begin
          if (cnt == 16'h0000)
          begin
            // Results are loaded on the same edge that drops busy.
            state <= rmd_pkg::ST_IDLE;
            err <= diag_code;
            errb <= 1'b0;
            df <= 1'b0;
            bsy <= 1'b0;
            drdy <= 1'b1;
          end
          else
          begin
            cnt <= 16'(cnt - 16'h0001);
          end
        end
      endcase
    end
  end

  // Microcode is handed on as apply-now or apply-and-keep once accepted.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ucode_apply_o <= 1'b0;
      ucode_keep_o <= 1'b0;
    end
    else
    begin
      ucode_apply_o <= ucode_check_o && ucode_accept_i && !ucode_reject_i && !rst_go;
      if (ucode_check_o && ucode_accept_i && !ucode_reject_i && !rst_go)
      begin
        ucode_keep_o <= feat == rmd_pkg::SUB_SAVE;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  reset_takes_busy_a: assert property (rst_go |=> bsy && !drq && state == rmd_pkg::ST_RESET)
    else $error("reset command not taken");
  reset_no_error_a: assert property (state == rmd_pkg::ST_RESET && cnt == 16'h0000 && !rst_go
    |=> !bsy && !errb && err == $past(diag_code) && drdy)
    else $error("reset ended wrongly");
  reset_unsup_abort_a: assert property (rst_abort |=> errb && err[rmd_pkg::ERR_ABRT] && !bsy)
    else $error("unsupported reset not aborted");
  signature_select_a: assert property (sig_load && !rst_go
    |=> dsel == (8'($past(cfg[rmd_pkg::CFG_DEV1])) << rmd_pkg::DSEL_DEV) && cnt_lo == SIG_CNT)
    else $error("signature not loaded");
  packet_dl_abort_a: assert property (ucode_cmd && cfg[rmd_pkg::CFG_PACKET] && !rst_go
    |=> errb && err[rmd_pkg::ERR_ABRT] && !drq)
    else $error("download not refused");
  zero_count_a: assert property (ucode_go && count_total == 16'h0000 |=> bsy && !drq && ucode_check_o)
    else $error("zero count took a data phase");
  dl_success_a: assert property (ucode_check_o && ucode_accept_i && !ucode_reject_i && !rst_go
    |=> !bsy && !df && !drq && !errb && drdy && ucode_apply_o ##1 !ucode_apply_o)
    else $error("download success status wrong");
  dl_reject_a: assert property (ucode_check_o && ucode_reject_i && !rst_go
    |=> errb && err[rmd_pkg::ERR_ABRT] && drdy && !bsy && !drq && df == $past(dev_fault_i))
    else $error("download abort status wrong");
  diag_busy_hold_a: assert property ((diag_go || (state == rmd_pkg::ST_DIAG && cnt != 16'h0000)) && !rst_go
    |=> bsy && state == rmd_pkg::ST_DIAG)
    else $error("diagnostic dropped busy early");
  cover_reset_c: cover property (rst_go ##[1:200] !bsy);
  cover_dl_c: cover property (ucode_go ##[1:1000] ucode_apply_o);
  cover_diag_c: cover property (diag_go ##[1:200] !bsy);
endmodule
`default_nettype wire

//--- testbench/rmd_fw_model.sv
// Purpose: Firmware stand-in that judges a downloaded microcode image.
// Assumes: The core holds check high until it sees a verdict.
// Notes: The verdict is chosen by the bench; the image content is never inspected.
`timescale 1ns/1ps
`default_nettype none
module rmd_fw_model #(
  parameter int DELAY = 8
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Request from the core and verdict choice from the bench.
  input wire logic check_i,
  input wire logic reject_mode_i,
  // Verdict back to the core.
  output logic accept_o,
  output logic reject_o
);
  int wait_cnt;

  // A slow verdict keeps the core busy long enough for the bench to see it waiting.
  always_ff @(posedge clk_i)
  begin
    accept_o <= 1'b0;
    reject_o <= 1'b0;
    if (rst_i || !check_i)
    begin
      wait_cnt <= 0;
    end
    else if (wait_cnt == DELAY)
    begin
      accept_o <= !reject_mode_i;
      reject_o <= reject_mode_i;
      wait_cnt <= 0;
    end
    else
    begin
      wait_cnt <= wait_cnt + 1;
    end
  end
endmodule
`default_nettype wire

//--- testbench/tb_reset_microcode_diag_cmds.sv
// Purpose: Self-checking bench for the reset, microcode and diagnostic command block.
// Assumes: Counts shortened to 8 cycles; signature values are arbitrary.
// Notes: All register traffic goes through one classic Wishbone task.
`timescale 1ns/1ps
`default_nettype none
module tb_reset_microcode_diag_cmds;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic diag_fail_i = 1'b0;
  logic dev_fault_i = 1'b0;
  logic fw_reject = 1'b0;
  logic ucode_accept_i;
  logic ucode_reject_i;
  logic [7:0] ucode_rd_addr_i = 8'h05;
  logic [15:0] ucode_rd_data_o;
  logic ucode_check_o;
  logic ucode_apply_o;
  logic ucode_keep_o;
  int err_count = 0;
  int checked = 0;
  int apply_cnt = 0;

  rmd_cmd_core #(.RESET_CYCLES(8), .DIAG_CYCLES(8), .SIG_CNT(8'h3c), .SIG_NUM(8'hc3), .SIG_TRK_LO(8'h5a),
    .SIG_TRK_HI(8'ha5)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .diag_fail_i(diag_fail_i), .dev_fault_i(dev_fault_i), .ucode_accept_i(ucode_accept_i),
    .ucode_reject_i(ucode_reject_i), .ucode_rd_addr_i(ucode_rd_addr_i), .ucode_rd_data_o(ucode_rd_data_o),
    .ucode_check_o(ucode_check_o), .ucode_apply_o(ucode_apply_o), .ucode_keep_o(ucode_keep_o));

  rmd_fw_model fw (.clk_i(clk_i), .rst_i(rst_i), .check_i(ucode_check_o), .reject_mode_i(fw_reject),
    .accept_o(ucode_accept_i), .reject_o(ucode_reject_i));

  // Clock at 250 MHz.
  always #2 clk_i = ~clk_i;

  // Count apply pulses so a doubled or missing pulse shows.
  always @(posedge clk_i)
  begin
    if (ucode_apply_o === 1'b1)
      apply_cnt <= apply_cnt + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic cycle; the request stands until ack is seen at a rising edge.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1)
      @(posedge clk_i);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask

  // Poll status a bounded number of times until busy clears.
  task automatic wait_idle();
    logic [31:0] q;
    int n;
    n = 0;
    q = 32'h80;
    while (q[7] !== 1'b0 && n < 64)
    begin
      bus(1'b0, rmd_pkg::ADR_STAT, 32'h0, q);
      n++;
    end
    chk({31'h0, q[7]}, 32'h0);
  endtask

  // Full download: host loads the parameters, sends data, then the verdict is checked.
  task automatic dl(input logic [7:0] cfg, input logic [7:0] sub, input logic [15:0] cnt, input logic rej,
    input logic flt, input logic [7:0] st);
    wr(rmd_pkg::ADR_CFG, {24'h0, cfg});
    wr(rmd_pkg::ADR_FEAT, {24'h0, sub});
    wr(rmd_pkg::ADR_CNT_LO, {24'h0, cnt[7:0]});
    wr(rmd_pkg::ADR_CNT_HI, {24'h0, cnt[15:8]});
    wr(rmd_pkg::ADR_TRK_LO, 32'h0);
    wr(rmd_pkg::ADR_TRK_HI, 32'h0);
    wr(rmd_pkg::ADR_DSEL, 32'h0);
    dev_fault_i <= flt;
    fw_reject <= rej;
    wr(rmd_pkg::ADR_CMD, {24'h0, rmd_pkg::CMD_UCODE});
    if (cnt != 16'h0)
    begin
      rchk(rmd_pkg::ADR_STAT, 32'h88, 32'h08);
      for (int i = 0; i < rmd_pkg::BLOCK_WORDS * cnt; i++)
        wr(rmd_pkg::ADR_DATA, {16'h0, i[15:0]});
      rchk(rmd_pkg::ADR_STAT, 32'h88, 32'h80);
    end
    wait_idle();
    rchk(rmd_pkg::ADR_STAT, 32'hff, {24'h0, st});
    if (st[0])
      rchk(rmd_pkg::ADR_ERR, 32'hff, 32'h04);
  endtask

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Watchdog sized well above the roughly 1200 cycles the tests need.
  initial
  begin
    repeat (50000) @(posedge clk_i);
    err_count++;
    final_report();
  end

  initial
  begin
    logic [7:0] dcfg [3] = '{8'h18, 8'h1a, 8'h1a};
    logic dfail [3] = '{1'b0, 1'b0, 1'b1};
    logic [7:0] dexp [3] = '{8'h01, 8'h81, 8'h82};
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(rmd_pkg::ADR_STAT, 32'hff, 32'h40);
    rchk(rmd_pkg::ADR_CFG, 32'hff, 32'h18);
    rchk(8'h2c, 32'hffffffff, 32'h0);
    // Reset without the packet set is refused while idle.
    wr(rmd_pkg::ADR_CMD, {24'h0, rmd_pkg::CMD_DEV_RESET});
    rchk(rmd_pkg::ADR_STAT, 32'h81, 32'h01);
    rchk(rmd_pkg::ADR_ERR, 32'hff, 32'h04);
    // Reset in sleep, the second one while the first is still busy.
    wr(rmd_pkg::ADR_CFG, 32'h1d);
    wr(rmd_pkg::ADR_DSEL, 32'h0f);
    wr(rmd_pkg::ADR_CMD, {24'h0, rmd_pkg::CMD_DEV_RESET});
    wr(rmd_pkg::ADR_CMD, {24'h0, rmd_pkg::CMD_DEV_RESET});
    rchk(rmd_pkg::ADR_STAT, 32'h80, 32'h80);
    wait_idle();
    rchk(rmd_pkg::ADR_STAT, 32'hff, 32'h40);
    rchk(rmd_pkg::ADR_ERR, 32'hff, 32'h01);
    rchk(rmd_pkg::ADR_CNT_LO, 32'hff, 32'h3c);
    rchk(rmd_pkg::ADR_CNT_HI, 32'hff, 32'hc3);
    rchk(rmd_pkg::ADR_TRK_LO, 32'hff, 32'h5a);
    rchk(rmd_pkg::ADR_TRK_HI, 32'hff, 32'ha5);
    rchk(rmd_pkg::ADR_DSEL, 32'hff, 32'h00);
    // A reset addressed to the other device leaves this one alone.
    wr(rmd_pkg::ADR_CNT_LO, 32'h55);
    wr(rmd_pkg::ADR_DSEL, 32'h10);
    wr(rmd_pkg::ADR_CMD, {24'h0, rmd_pkg::CMD_DEV_RESET});
    rchk(rmd_pkg::ADR_STAT, 32'hff, 32'h40);
    rchk(rmd_pkg::ADR_CNT_LO, 32'hff, 32'h55);
    // A byte write without lane 0 selected must leave the register alone.
    wb_sel_i <= 4'he;
    wr(rmd_pkg::ADR_CNT_LO, 32'haa);
    wb_sel_i <= 4'hf;
    rchk(rmd_pkg::ADR_CNT_LO, 32'hff, 32'h55);
    // Diagnostics on both device numbers, pass and fail, select matching only in the device 1 fail run.
    for (int k = 0; k < 3; k++)
    begin
      wr(rmd_pkg::ADR_CFG, {24'h0, dcfg[k]});
      diag_fail_i <= dfail[k];
      wr(rmd_pkg::ADR_CMD, {24'h0, rmd_pkg::CMD_DIAG});
      wait_idle();
      rchk(rmd_pkg::ADR_ERR, 32'hff, {24'h0, dexp[k]});
      rchk(rmd_pkg::ADR_STAT, 32'hff, 32'h40);
    end
    diag_fail_i <= 1'b0;
    // Downloads: success with data, empty save, and the abort paths.
    dl(8'h18, rmd_pkg::SUB_TEMP, 16'h0001, 1'b0, 1'b0, 8'h40);
    chk({31'h0, ucode_keep_o}, 32'h0);
    chk({16'h0, ucode_rd_data_o}, 32'h5);
    // The last word of the block shows that all 256 words were stored.
    ucode_rd_addr_i <= 8'hff;
    repeat (2) @(posedge clk_i);
    chk({16'h0, ucode_rd_data_o}, 32'hff);
    dl(8'h18, rmd_pkg::SUB_SAVE, 16'h0000, 1'b0, 1'b0, 8'h40);
    chk({31'h0, ucode_keep_o}, 32'h1);
    dl(8'h08, rmd_pkg::SUB_SAVE, 16'h0000, 1'b0, 1'b1, 8'h61);
    dl(8'h18, 8'h05, 16'h0000, 1'b0, 1'b0, 8'h41);
    dl(8'h18, rmd_pkg::SUB_TEMP, 16'h0000, 1'b1, 1'b0, 8'h41);
    dl(8'h19, rmd_pkg::SUB_TEMP, 16'h0000, 1'b0, 1'b0, 8'h41);
    chk(32'(apply_cnt), 32'h2);
    final_report();
  end
endmodule
`default_nettype wire
